// file: rtl/cmp_defines.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  analog threshold comparator. Assumes a 10 MHz system clock.
*/
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

// ----------------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_LEVEL       4'h1
`define REG_BAND        4'h2
`define REG_WIN_LEN     4'h3
`define REG_ASSERT_DLY  4'h4
`define REG_DEASSERT_DLY 4'h5
`define REG_BASE_GEN    4'h6
`define REG_RANGE_PLUS  4'h7
`define REG_RANGE_MINUS 4'h8
`define REG_STATUS      4'h9
`define REG_OPERATE     4'hA

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define CTRL_ENABLE     0
`define CTRL_PLUS_ON    1
`define CTRL_MINUS_ON   2
`define CTRL_MAGNITUDE  3
`define CTRL_RATE       4
`define CTRL_UNDER      5
`define CTRL_UNIT_LO    8
`define CTRL_UNIT_HI    9
`define CTRL_QTY_LO     12
`define CTRL_QTY_HI     14

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define RST_LEVEL       32'h000003E8
`define RST_BAND        10'h01E
`define BAND_MIN        10'h001
`define BAND_MAX        10'h1F4
`define RST_WIN_LEN     17'h00014
`define RST_BASE        32'h00000001

// ----------------------------------------------------------------------
// per-unit bases and timing
// ----------------------------------------------------------------------
`define MILLI_DIV       64'sh00000000000003E8
`define HARM_BASE       32'h00002710
`define ENERGY_BASE     32'h00002710
`define ANGLE_BASE      32'h00008CA0
`define MS_PER_MS       17'h00001
`define MS_PER_SEC      17'h003E8
`define MS_PER_MIN      17'h0EA60
`define TICK_TIME_NS    1000000
`define CLK_PERIOD_NS   100

`endif

// file: rtl/cmp_pkg.sv
/*
  Types of the analog threshold comparator: quantity kinds, window units,
  window states and the state records of both modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cmp_pkg;

  typedef enum logic [2:0] {
    QTY_GENERIC   = 3'h0,
    QTY_HARMONIC  = 3'h1,
    QTY_ENERGY    = 3'h2,
    QTY_ANGLE     = 3'h3,
    QTY_DCMA      = 3'h4,
    QTY_SYNC_VOLT = 3'h5
  } qty_t;

  typedef enum logic [1:0] {
    DT_MS  = 2'h0,
    DT_SEC = 2'h1,
    DT_MIN = 2'h2
  } dt_unit_t;

  typedef enum logic [2:0] {
    WIN_IDLE  = 3'b001,
    WIN_FILL  = 3'b010,
    WIN_READY = 3'b100
  } win_state_t;

  typedef struct packed {
    logic               enable;
    logic               plus_on;
    logic               minus_on;
    logic               mag;
    logic               rate;
    logic               dir_under;
    dt_unit_t           unit;
    qty_t               qty;
    logic signed [31:0] level;
    logic [9:0]         band_pct;
    logic [16:0]        win_len;
    logic [15:0]        pkp_dly;
    logic [15:0]        rst_dly;
    logic [31:0]        base_gen;
    logic [31:0]        rng_plus;
    logic [31:0]        rng_minus;
    logic signed [33:0] diff;
    logic signed [33:0] refv;
    logic signed [34:0] delta;
    win_state_t         win;
    logic [15:0]        tick_cnt;
    logic               tick;
    logic [16:0]        unit_cnt;
    logic [16:0]        len_cnt;
    logic               cond;
    logic [31:0]        rdata;
  } cmp_state_t;

  typedef struct packed {
    logic        out;
    logic [15:0] cnt;
  } tmr_state_t;

endpackage

// file: rtl/delay_timer.sv
/*
  Pickup / reset delay timer for the comparator output flag.
  Assumes a one-cycle millisecond tick and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "cmp_defines.svh"

module delay_timer
  import cmp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        tick_i,
  input  wire logic        cond_i,
  input  wire logic [15:0] pkp_dly_i,
  input  wire logic [15:0] rst_dly_i,
  output logic             out_o
);
  import cmp_pkg::*;

  tmr_state_t st;
  tmr_state_t next_st;
  logic [15:0] target;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    target  = cond_i ? pkp_dly_i : rst_dly_i;
    if (cond_i == st.out) begin
      next_st.cnt = 16'h0000;                      // see R20
    end else if (target == 16'h0000) begin
      next_st.out = cond_i;
      next_st.cnt = 16'h0000;
    end else if (tick_i) begin
      // resolution is one tick; first tick may come early by up to 1 ms
      if (st.cnt + 16'h0001 >= target) begin
        next_st.out = cond_i;                      // see R13 see R14
        next_st.cnt = 16'h0000;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_o = st.out;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_pend_pick;
    !st.out && cond_i;
  endsequence

  property p_zero_pick;
    @(posedge clk_i) disable iff (!nrst_i)
      s_pend_pick ##0 (pkp_dly_i == 16'h0000) |=> st.out;
  endproperty
  a_zero_pick: assert property (p_zero_pick) else $error("zero pickup delay not immediate"); // see R13

  property p_pick_waits;
    @(posedge clk_i) disable iff (!nrst_i)
      s_pend_pick ##0 (pkp_dly_i != 16'h0000) ##0 !tick_i |=> !st.out;
  endproperty
  a_pick_waits: assert property (p_pick_waits) else $error("output rose without delay"); // see R13

  property p_reset_holds;
    @(posedge clk_i) disable iff (!nrst_i)
      (st.out && !cond_i && rst_dly_i != 16'h0000 && !tick_i) |=> st.out;
  endproperty
  a_reset_holds: assert property (p_reset_holds) else $error("output fell without delay"); // see R14

  property p_restart;
    @(posedge clk_i) disable iff (!nrst_i)
      (cond_i == st.out) |=> (st.cnt == 16'h0000);
  endproperty
  a_restart: assert property (p_restart) else $error("delay count not restarted"); // see R20

endmodule // delay_timer

// file: rtl/threshold_comparator.sv
/*
  Analog threshold comparator: difference of two measured inputs, optional
  magnitude and rate of change, signed per-unit threshold with hysteresis,
  pickup and reset delays. Register file on a plain strobe port.
  Assumes input values and SAMPLE_I are synchronous to CLK_SYS_I (10 MHz).
*/
// Behaviour
// R1: over direction picks up above threshold
// R2: under direction picks up below threshold
// R3: hysteresis band is percent of pickup
// R4: signal and threshold are signed
// R5: any quantity, threshold per-unit by type
// R6: harmonics base is full fundamental
// R7: energy base is ten thousand MWh/Mvarh
// R8: angle base is 360 degrees
// R9: transducer base is larger range setting
// R10: sync voltage base is largest source voltage
// R11: window unit used only in rate mode
// R12: window length sets rate interval
// R13: output delayed by pickup delay
// R14: output held for reset delay
// R15: signal is plus minus minus, off zero
// R16: magnitude mode uses absolute value
// R17: rate mode acts on change of signal
// R18: hysteresis 0.1 to 50.0 percent
// R19: dropout at threshold minus/plus band
// R20: delay timers restart on condition change
`timescale 1ns/1ps
`include "cmp_defines.svh"

module threshold_comparator
  import cmp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic               CLK_SYS_I,
  input  wire logic               NRST_I,
  input  wire logic [3:0]         ADDR_I,
  input  wire logic [31:0]        WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  output logic      [31:0]        RDATA_O,
  input  wire logic signed [31:0] PLUS_VALUE_I,
  input  wire logic signed [31:0] MINUS_VALUE_I,
  input  wire logic               SAMPLE_I,
  input  wire logic [31:0]        SRC_VMAX_PLUS_I,
  input  wire logic [31:0]        SRC_VMAX_MINUS_I,
  output logic                    PICKUP_O,
  output logic                    OPERATE_O
);
  import cmp_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
    max32 = (a > b) ? a : b;
  endfunction

  function automatic logic signed [63:0] abs64(input logic signed [63:0] a);
    abs64 = (a < 64'sh0) ? -a : a;
  endfunction

  // milli scaling: threshold in 0.001 pu, band in 0.1 percent
  function automatic logic signed [63:0] scale_milli(input logic signed [63:0] a,
                                                     input logic signed [63:0] b);
    scale_milli = (a * b) / `MILLI_DIV;
  endfunction

  function automatic logic [16:0] unit_ms(input dt_unit_t u);
    case (u)
      DT_MS:   unit_ms = `MS_PER_MS;
      DT_SEC:  unit_ms = `MS_PER_SEC;
      DT_MIN:  unit_ms = `MS_PER_MIN;
      default: unit_ms = `MS_PER_MS;
    endcase
  endfunction

  cmp_state_t st;
  cmp_state_t next_st;

  logic signed [31:0] pv;
  logic signed [31:0] mv;
  logic [31:0]        base;
  logic signed [63:0] thr;
  logic signed [63:0] band;
  logic signed [63:0] raw;
  logic signed [63:0] op;
  logic               in_any;
  logic               op_ok;
  logic [16:0]        unit_last;
  logic [16:0]        win_last;
  logic [9:0]         band_wr;
  logic               timer_out;

  // ----------------------------------------------------------------------
  // operating signal and threshold
  // ----------------------------------------------------------------------
  always_comb begin
    pv     = st.plus_on  ? PLUS_VALUE_I  : 32'sh00000000;   // see R15
    mv     = st.minus_on ? MINUS_VALUE_I : 32'sh00000000;   // see R15
    in_any = st.plus_on || st.minus_on;
    case (st.qty)                                            // see R5
      QTY_HARMONIC:  base = `HARM_BASE;                      // see R6
      QTY_ENERGY:    base = `ENERGY_BASE;                    // see R7
      QTY_ANGLE:     base = `ANGLE_BASE;                     // see R8
      QTY_DCMA:      base = max32(st.rng_plus, st.rng_minus); // see R9
      QTY_SYNC_VOLT: base = max32(SRC_VMAX_PLUS_I, SRC_VMAX_MINUS_I); // see R10
      default:       base = st.base_gen;
    endcase
    thr  = scale_milli(64'(st.level), $signed({32'h00000000, base}));  // see R4
    band = scale_milli(abs64(thr), $signed({54'h0, st.band_pct}));     // see R3
    raw  = st.rate ? 64'(st.delta) : 64'(st.diff);           // see R17
    op   = st.mag ? abs64(raw) : raw;                        // see R16
    op_ok     = !st.rate || (st.win == WIN_READY);
    unit_last = unit_ms(st.unit) - 17'h00001;                // see R11
    win_last  = (st.win_len == 17'h00000) ? 17'h00000 : st.win_len - 17'h00001;
    if (WDATA_I[9:0] < `BAND_MIN) begin
      band_wr = `BAND_MIN;                                   // see R18
    end else if (WDATA_I[9:0] > `BAND_MAX || WDATA_I[31:10] != 22'h0) begin
      band_wr = `BAND_MAX;                                   // see R18
    end else begin
      band_wr = WDATA_I[9:0];
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;

    // millisecond tick shared by the window and the delay timer
    next_st.tick = 1'b0;
    if (st.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = 16'h0000;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end

    if (SAMPLE_I) begin
      next_st.diff = {{2{pv[31]}}, pv} - {{2{mv[31]}}, mv};  // see R15
    end

    // rate window: counts whole units of ms, then whole units of length
    if (!st.rate || !st.enable) begin
      next_st.win      = WIN_IDLE;                           // see R11
      next_st.unit_cnt = 17'h00000;
      next_st.len_cnt  = 17'h00000;
    end else begin
      case (st.win)
        WIN_IDLE: begin
          next_st.refv     = st.diff;
          next_st.win      = WIN_FILL;
          next_st.unit_cnt = 17'h00000;
          next_st.len_cnt  = 17'h00000;
        end
        WIN_FILL, WIN_READY: begin
          if (st.tick) begin
            if (st.unit_cnt >= unit_last) begin
              next_st.unit_cnt = 17'h00000;
              if (st.len_cnt >= win_last) begin
                next_st.len_cnt = 17'h00000;
                next_st.delta   = 35'(st.diff) - 35'(st.refv); // see R12
                next_st.refv    = st.diff;
                next_st.win     = WIN_READY;
              end else begin
                next_st.len_cnt = st.len_cnt + 17'h00001;
              end
            end else begin
              next_st.unit_cnt = st.unit_cnt + 17'h00001;
            end
          end
        end
        default: begin
          next_st.win = WIN_IDLE;
        end
      endcase
    end

    // pickup condition with hysteresis; no inputs means never operate
    if (!st.enable || !in_any || !op_ok) begin
      next_st.cond = 1'b0;
    end else if (!st.dir_under) begin
      if (!st.cond && op > thr) begin
        next_st.cond = 1'b1;                                 // see R1
      end else if (st.cond && op < thr - band) begin
        next_st.cond = 1'b0;                                 // see R19
      end
    end else begin
      if (!st.cond && op < thr) begin
        next_st.cond = 1'b1;                                 // see R2
      end else if (st.cond && op > thr + band) begin
        next_st.cond = 1'b0;                                 // see R19
      end
    end

    // register writes
    if (WR_I) begin
      case (ADDR_I)
        `REG_CTRL: begin
          next_st.enable    = WDATA_I[`CTRL_ENABLE];
          next_st.plus_on   = WDATA_I[`CTRL_PLUS_ON];
          next_st.minus_on  = WDATA_I[`CTRL_MINUS_ON];
          next_st.mag       = WDATA_I[`CTRL_MAGNITUDE];
          next_st.rate      = WDATA_I[`CTRL_RATE];
          next_st.dir_under = WDATA_I[`CTRL_UNDER];
          next_st.unit      = dt_unit_t'(WDATA_I[`CTRL_UNIT_HI:`CTRL_UNIT_LO]);
          next_st.qty       = qty_t'(WDATA_I[`CTRL_QTY_HI:`CTRL_QTY_LO]);
        end
        `REG_LEVEL:        next_st.level     = WDATA_I;
        `REG_BAND:         next_st.band_pct  = band_wr;
        `REG_WIN_LEN:      next_st.win_len   = WDATA_I[16:0];
        `REG_ASSERT_DLY:   next_st.pkp_dly   = WDATA_I[15:0];
        `REG_DEASSERT_DLY: next_st.rst_dly   = WDATA_I[15:0];
        `REG_BASE_GEN:     next_st.base_gen  = WDATA_I;
        `REG_RANGE_PLUS:   next_st.rng_plus  = WDATA_I;
        `REG_RANGE_MINUS:  next_st.rng_minus = WDATA_I;
        default: begin
        end
      endcase
    end

    // read data stand for exactly one cycle after the strobe
    next_st.rdata = 32'h00000000;
    if (RD_I) begin
      case (ADDR_I)
        `REG_CTRL: begin
          next_st.rdata[`CTRL_ENABLE]    = st.enable;
          next_st.rdata[`CTRL_PLUS_ON]   = st.plus_on;
          next_st.rdata[`CTRL_MINUS_ON]  = st.minus_on;
          next_st.rdata[`CTRL_MAGNITUDE] = st.mag;
          next_st.rdata[`CTRL_RATE]      = st.rate;
          next_st.rdata[`CTRL_UNDER]     = st.dir_under;
          next_st.rdata[`CTRL_UNIT_HI:`CTRL_UNIT_LO] = st.unit;
          next_st.rdata[`CTRL_QTY_HI:`CTRL_QTY_LO]   = st.qty;
        end
        `REG_LEVEL:        next_st.rdata = st.level;
        `REG_BAND:         next_st.rdata = {22'h000000, st.band_pct};
        `REG_WIN_LEN:      next_st.rdata = {15'h0000, st.win_len};
        `REG_ASSERT_DLY:   next_st.rdata = {16'h0000, st.pkp_dly};
        `REG_DEASSERT_DLY: next_st.rdata = {16'h0000, st.rst_dly};
        `REG_BASE_GEN:     next_st.rdata = st.base_gen;
        `REG_RANGE_PLUS:   next_st.rdata = st.rng_plus;
        `REG_RANGE_MINUS:  next_st.rdata = st.rng_minus;
        `REG_STATUS:       next_st.rdata = {29'h00000000, op_ok, timer_out, st.cond};
        // operating signal truncated to its low 32 bits, no saturation
        `REG_OPERATE:      next_st.rdata = op[31:0];
        default:           next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      st          <= '0;
      st.unit     <= DT_MS;
      st.qty      <= QTY_GENERIC;
      st.level    <= `RST_LEVEL;
      st.band_pct <= `RST_BAND;
      st.win_len  <= `RST_WIN_LEN;
      st.base_gen <= `RST_BASE;
      st.rng_plus <= `RST_BASE;
      st.rng_minus <= `RST_BASE;
      st.win      <= WIN_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // output delay
  // ----------------------------------------------------------------------
  delay_timer u_delay (
    .clk_i     (CLK_SYS_I),
    .nrst_i    (NRST_I),
    .tick_i    (st.tick),
    .cond_i    (st.cond),      // see R13 see R14
    .pkp_dly_i (st.pkp_dly),
    .rst_dly_i (st.rst_dly),
    .out_o     (timer_out)
  );

  assign RDATA_O   = st.rdata;
  assign PICKUP_O  = st.cond;
  assign OPERATE_O = timer_out;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_armed;
    st.enable && in_any && op_ok && !WR_I;
  endsequence

  property p_over_pick;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      s_armed ##0 (!st.dir_under && !st.cond && op > thr) |=> st.cond;
  endproperty
  a_over_pick: assert property (p_over_pick) else $error("over pickup missed"); // see R1

  property p_under_pick;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      s_armed ##0 (st.dir_under && !st.cond && op < thr) |=> st.cond;
  endproperty
  a_under_pick: assert property (p_under_pick) else $error("under pickup missed"); // see R2

  property p_over_hold;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      s_armed ##0 (!st.dir_under && st.cond && op >= thr - band) |=> st.cond;
  endproperty
  a_over_hold: assert property (p_over_hold) else $error("dropout inside band"); // see R19

  property p_under_drop;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      s_armed ##0 (st.dir_under && st.cond && op > thr + band) |=> !st.cond;
  endproperty
  a_under_drop: assert property (p_under_drop) else $error("under dropout missed"); // see R19

  property p_no_input;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (!st.plus_on && !st.minus_on && !WR_I) |=> !st.cond;
  endproperty
  a_no_input: assert property (p_no_input) else $error("picked up with no input"); // see R15

  property p_diff;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (SAMPLE_I && !WR_I) |=> (st.diff == 34'($past(pv)) - 34'($past(mv)));
  endproperty
  a_diff: assert property (p_diff) else $error("difference not taken"); // see R15

  property p_magnitude;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      st.mag |-> (op >= 64'sh0);
  endproperty
  a_magnitude: assert property (p_magnitude) else $error("negative in magnitude mode"); // see R16

  property p_level_idle;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (!st.rate && !WR_I) |=> (st.win == WIN_IDLE) && (st.unit_cnt == 17'h00000);
  endproperty
  a_level_idle: assert property (p_level_idle) else $error("window runs in level mode"); // see R11

  property p_window_end;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (st.rate && st.enable && st.win != WIN_IDLE && st.tick && !WR_I &&
       st.unit_cnt >= unit_last && st.len_cnt >= win_last)
      |=> (st.win == WIN_READY) && (st.delta == 35'($past(st.diff)) - 35'($past(st.refv)));
  endproperty
  a_window_end: assert property (p_window_end) else $error("rate window end wrong"); // see R12

  property p_band_range;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (st.band_pct >= `BAND_MIN) && (st.band_pct <= `BAND_MAX);
  endproperty
  a_band_range: assert property (p_band_range) else $error("band outside range"); // see R18

endmodule // threshold_comparator

// file: testbench/meas_engine.sv
/*
  Measurement engine model: hands plus and minus values to the comparator
  with a one-cycle sample pulse; source voltage maxima are fixed.
  Assumes go_i comes from the bench, synchronous to clk_i.
*/
`timescale 1ns/1ps
module meas_engine #(
  parameter logic [31:0] VMAX_P = 32'h00000BB8,
  parameter logic [31:0] VMAX_M = 32'h00001F40
) (
  input  wire logic               clk_i,
  input  wire logic               go_i,
  input  wire logic signed [31:0] p_i,
  input  wire logic signed [31:0] m_i,
  output logic signed      [31:0] plus_o,
  output logic signed      [31:0] minus_o,
  output logic                    sample_o,
  output logic             [31:0] vp_o,
  output logic             [31:0] vm_o
);
  logic signed [31:0] p_q = 32'sh00000000;
  logic signed [31:0] m_q = 32'sh00000000;
  logic               s_q = 1'b0;
  assign vp_o     = VMAX_P;
  assign vm_o     = VMAX_M;
  assign plus_o   = p_q;
  assign minus_o  = m_q;
  assign sample_o = s_q;
  // values churn outside the pulse, so a capture off the pulse shows up
  always @(posedge clk_i) begin
    s_q <= go_i;
    p_q <= go_i ? p_i : ~p_q;
    m_q <= go_i ? m_i : ~m_q;
  end
endmodule // meas_engine

// file: testbench/threshold_comparator_tb.sv
/*
  Self-checking bench: register reads, a table of level cases, then
  delays, reset and rate mode. Assumes meas_engine and TICK_CYCLES of 4.
*/
`timescale 1ns/1ps
module threshold_comparator_tb;
  typedef struct {logic [15:0] c; int l; int p; int m; logic e;} row_t;
  logic               clk, nrst, wr, rd, go, pk, op, smpl;
  logic        [3:0]  addr;
  logic        [31:0] wdata, rdata, vp, vm;
  logic signed [31:0] pv, mv, plus, minus;
  int                 n_errors, tests_run, n;
  logic        [35:0] rst_tab[11] = '{36'h000000000, 36'h1000003E8, 36'h20000001E,
    36'h300000014, 36'h400000000, 36'h500000000, 36'h600000001, 36'h700000001,
    36'h800000001, 36'h900000004, 36'hF00000000};
  row_t rows[18] = '{'{16'h0207, 1000, 1500, 400, 1}, '{16'h0207, 1000, 1380, 400, 1},
    '{16'h0207, 1000, 1360, 400, 0}, '{16'h0027, -500, -600, 0, 1},
    '{16'h0027, -500, -490, 0, 1}, '{16'h0027, -500, -480, 0, 0},
    '{16'h000F, 1000, -1200, 0, 1}, '{16'h0003, 1000, 500, -9000, 0},
    '{16'h0005, 1000, -9000, -1100, 1}, '{16'h0002, 1000, 9000, 0, 0},
    '{16'h3003, 500, 17000, 0, 0}, '{16'h3003, 500, 18100, 0, 1},
    '{16'h1003, 500, 4000, 0, 0}, '{16'h2003, 500, 4900, 0, 0},
    '{16'h2003, 500, 5100, 0, 1}, '{16'h4003, 500, 1000, 0, 0},
    '{16'h5003, 500, 3000, 0, 0}, '{16'h5003, 500, 4100, 0, 1}};

  threshold_comparator #(.TICK_CYCLES(4)) dut_u (.CLK_SYS_I(clk), .NRST_I(nrst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PLUS_VALUE_I(plus), .MINUS_VALUE_I(minus), .SAMPLE_I(smpl),
    .SRC_VMAX_PLUS_I(vp), .SRC_VMAX_MINUS_I(vm), .PICKUP_O(pk), .OPERATE_O(op));
  meas_engine eng_u (.clk_i(clk), .go_i(go), .p_i(pv), .m_i(mv), .plus_o(plus),
    .minus_o(minus), .sample_o(smpl), .vp_o(vp), .vm_o(vm));

  // ----------------------------------------------------------------------
  // bus, sample and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_rng(input string s, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, n);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk);
    #1 chk("rdata idle", 32'h0, rdata);
  endtask
  task automatic smp(input int p, input int m);
    @(posedge clk);
    pv <= p;
    mv <= m;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // bounded wait on the flag; o picks the delayed output
  task automatic wait_for(input logic o, input logic v, input int lim);
    #1 n = 0;
    while (n < lim && (o ? op : pk) !== v) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    {nrst, wr, rd, go, addr, wdata, pv, mv} = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_tab[i]) rd_reg(rst_tab[i][35:32], rst_tab[i][31:0]);
    wr_reg(4'h2, 32'h0);
    rd_reg(4'h2, 32'h1);
    wr_reg(4'h2, 32'h3E7);
    rd_reg(4'h2, 32'h1F4);
    wr_reg(4'h2, 32'h1E);
    wr_reg(4'h6, 32'h3E8);
    wr_reg(4'h7, 32'hC8);
    wr_reg(4'h8, 32'hFA0);
    foreach (rows[i]) begin
      wr_reg(4'h0, {16'h0, rows[i].c});
      wr_reg(4'h1, rows[i].l);
      smp(rows[i].p, rows[i].m);
      repeat (4) @(posedge clk);
      #1 chk("pickup", rows[i].e, pk);
      chk("operate", rows[i].e, op);
    end
    rd_reg(4'h9, 32'h7);
    rd_reg(4'hA, 32'h1004);
    // delays of 5 and 3 ms, tick every 4 clocks; first tick may be early
    wr_reg(4'h4, 32'h5);
    wr_reg(4'h5, 32'h3);
    smp(0, 0);
    wait_for(1'b1, 1'b0, 40);
    chk_rng("reset delay", 9, 17);
    smp(4100, 0);
    wait_for(1'b1, 1'b1, 40);
    chk_rng("pickup delay", 17, 25);
    smp(0, 0);
    repeat (6) @(posedge clk);
    smp(4100, 0);
    wait_for(1'b1, 1'b0, 30);
    chk_rng("output held", 30, 30);
    smp(0, 0);
    wait_for(1'b1, 1'b0, 40);
    chk_rng("restarted reset delay", 9, 17);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("reset outputs", 32'h0, {pk, op});
    @(posedge clk);
    nrst <= 1'b1;
    rd_reg(4'h1, 32'h3E8);
    wr_reg(4'h6, 32'h3E8);
    wr_reg(4'h1, 32'h64);
    wr_reg(4'h0, 32'h13);
    smp(500, 0);
    repeat (200) @(posedge clk);
    #1 chk("rate steady", 32'h0, pk);
    smp(700, 0);
    wait_for(1'b0, 1'b1, 100);
    chk_rng("rate pickup", 1, 99);
    wait_for(1'b0, 1'b0, 100);
    chk_rng("rate window", 70, 90);
    final_report();
  end
endmodule // threshold_comparator_tb
